/* File: inc/t16oc_pkg.sv */
// constants shared by the timer compare block
package t16oc_pkg;
  // register word offsets
  localparam logic [3:0] T16OC_OFF_CTRL = 4'h0;
  localparam logic [3:0] T16OC_OFF_FORCE = 4'h1;
  localparam logic [3:0] T16OC_OFF_COUNT = 4'h2;
  localparam logic [3:0] T16OC_OFF_CMPA = 4'h3;
  localparam logic [3:0] T16OC_OFF_CMPB = 4'h4;
  localparam logic [3:0] T16OC_OFF_CAPT = 4'h5;
  localparam logic [3:0] T16OC_OFF_FLAGS = 4'h6;
  localparam logic [3:0] T16OC_OFF_PIN = 4'h7;
  // control field positions
  localparam int T16OC_CTRL_MODE_LSB = 0;
  localparam int T16OC_CTRL_ACTA_LSB = 4;
  localparam int T16OC_CTRL_ACTB_LSB = 6;
  // force strobe bits
  localparam int T16OC_FORCE_A_BIT = 0;
  localparam int T16OC_FORCE_B_BIT = 1;
  // flag bits
  localparam int T16OC_FLAG_OVF_BIT = 0;
  localparam int T16OC_FLAG_MA_BIT = 1;
  localparam int T16OC_FLAG_MB_BIT = 2;
  // pin control bits
  localparam int T16OC_PIN_PORTA_BIT = 0;
  localparam int T16OC_PIN_DIRA_BIT = 1;
  localparam int T16OC_PIN_PORTB_BIT = 2;
  localparam int T16OC_PIN_DIRB_BIT = 3;
  // reset values
  localparam logic [15:0] T16OC_RST_WORD = 16'h0000;
  localparam logic [3:0] T16OC_RST_MODE = 4'h0;
  localparam logic [1:0] T16OC_RST_ACT = 2'h0;
  localparam logic T16OC_RST_STATE = 1'b0;
  // waveform modes and counter limits
  localparam logic [3:0] T16OC_MODE_NORMAL = 4'h0;
  localparam logic [3:0] T16OC_MODE_CTC_CMPA = 4'h4;
  localparam logic [3:0] T16OC_MODE_FAST8 = 4'h5;
  localparam logic [3:0] T16OC_MODE_FAST9 = 4'h6;
  localparam logic [3:0] T16OC_MODE_FAST10 = 4'h7;
  localparam logic [3:0] T16OC_MODE_CTC_CAPT = 4'hC;
  localparam logic [3:0] T16OC_MODE_RESV = 4'hD;
  localparam logic [3:0] T16OC_MODE_FAST_CAPT = 4'hE;
  localparam logic [3:0] T16OC_MODE_FAST_CMPA = 4'hF;
  localparam logic [15:0] T16OC_MAX = 16'hFFFF;
  localparam logic [15:0] T16OC_BOTTOM = 16'h0000;
  localparam logic [15:0] T16OC_TOP8 = 16'h00FF;
  localparam logic [15:0] T16OC_TOP9 = 16'h01FF;
  localparam logic [15:0] T16OC_TOP10 = 16'h03FF;
  // output action codes
  localparam logic [1:0] T16OC_ACT_NONE = 2'h0;
  localparam logic [1:0] T16OC_ACT_TOGGLE = 2'h1;
  localparam logic [1:0] T16OC_ACT_CLEAR = 2'h2;
  localparam logic [1:0] T16OC_ACT_SET = 2'h3;
endpackage

/* File: verilog/t16oc_channel.sv */
// one compare channel: comparator, match flag and output state
`timescale 1ns/100ps
module t16oc_channel
  import t16oc_pkg::*;
#(
  parameter int WIDTH = 16
) (
  input wire logic mclk, // system clock
  input wire logic resetn, // async reset, active low
  input wire logic [WIDTH-1:0] count, // timer_count
  input wire logic [WIDTH-1:0] compareValue, // compare_value
  input wire logic timerTick, // prescaled timer clock enable
  input wire logic blockMatch, // counter was written, drop next match
  input wire logic [1:0] compareOutputAction, // action field
  input wire logic pwmMode, // waveform mode is a pwm mode
  input wire logic topHit, // counter clears from top this tick
  input wire logic forceCompareStrobe, // forced compare, already gated
  input wire logic flagClear, // software clear of the match flag
  output logic compareMatchFlag, // sticky match flag
  output logic compareOutputState // internal output state
);
  logic matchEvent;
  logic stateNext;

  assign matchEvent = timerTick && !blockMatch && (count == compareValue);

  // flag is set by real matches only; set beats a same-cycle clear
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      compareMatchFlag <= 1'b0;
    end else if (matchEvent) begin
      compareMatchFlag <= 1'b1;
    end else if (flagClear) begin
      compareMatchFlag <= 1'b0;
    end
  end

  // action is read live so a new field governs the next match
  always_comb begin
    stateNext = compareOutputState;
    if (pwmMode) begin
      if (topHit) begin
        if (compareOutputAction == T16OC_ACT_CLEAR) stateNext = 1'b1;
        if (compareOutputAction == T16OC_ACT_SET) stateNext = 1'b0;
      end
      if (matchEvent) begin
        if (compareOutputAction == T16OC_ACT_CLEAR) stateNext = 1'b0;
        if (compareOutputAction == T16OC_ACT_SET) stateNext = 1'b1;
      end
    end else if (matchEvent || forceCompareStrobe) begin
      case (compareOutputAction)
        T16OC_ACT_TOGGLE: stateNext = !compareOutputState;
        T16OC_ACT_CLEAR: stateNext = 1'b0;
        T16OC_ACT_SET: stateNext = 1'b1;
        default: stateNext = compareOutputState;
      endcase
    end
  end

  // mode changes do not touch the state
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      compareOutputState <= T16OC_RST_STATE;
    end else begin
      compareOutputState <= stateNext;
    end
  end

  a_action_none_hold: assert property (
    @(posedge mclk) disable iff (!resetn)
    (compareOutputAction == T16OC_ACT_NONE) |=> $stable(compareOutputState)
  ) else $error("output state changed with no action selected");

  a_force_toggles: assert property (
    @(posedge mclk) disable iff (!resetn)
    (forceCompareStrobe && !pwmMode && compareOutputAction == T16OC_ACT_TOGGLE && !matchEvent)
      |=> (compareOutputState != $past(compareOutputState))
  ) else $error("forced compare did not toggle output state");
endmodule

/* File: verilog/t16oc_timer.sv */
// 16-bit timer with normal counting, two compare channels and pin override
// Functional notes
// - force strobe applies action like real match, in non-pwm modes only
// - force strobe sets no flag, keeps counter
// - counter write blocks next tick's matches
// - written top in pwm: count on to max
// - output state survives mode changes
// - action change affects next match only
// - reset clears output states to zero
// - nonzero action overrides port output value
// - pin driven only when direction selects output
// - actions never touch input capture
// - action zero leaves output state unchanged
// - counting depends only on waveform mode
// - pwm: actions select output polarity
// - non-pwm: actions set, clear or toggle
// - normal mode increments and wraps to zero
// - overflow set when counter wraps from max in non-pwm modes, or at top in fast pwm modes (never in default-decoded pwm modes)
// - overflow cleared when interrupt executes
// - normal mode accepts counter writes anytime
// - comparator sets match flag at tick
// - non-pwm modes are normal, both ctc and reserved
`timescale 1ns/100ps
module t16oc_timer
  import t16oc_pkg::*;
#(
  parameter int WIDTH = 16
) (
  input wire logic mclk, // system clock, 25 MHz
  input wire logic resetn, // async reset, active low
  input wire logic timerTick, // prescaled timer clock enable, mclk domain
  input wire logic overflowIntAck, // overflow interrupt executed, pulse
  input wire logic [3:0] regAddr, // register word address
  input wire logic [15:0] regWdata, // register write data
  input wire logic regWrite, // write strobe
  input wire logic regRead, // read strobe
  output logic [15:0] regRdata, // read data, cycle after strobe
  output logic pinOutA, // channel a pin level
  output logic pinOeNA, // channel a pin enable, low drives
  output logic pinOutB, // channel b pin level
  output logic pinOeNB, // channel b pin enable, low drives
  output logic overflowFlag, // overflow_flag
  output logic compareMatchFlagA, // compare_match_flag a
  output logic compareMatchFlagB // compare_match_flag b
);
  logic [3:0] waveformModeSelect_reg;
  logic [1:0] compareOutputActionA_reg;
  logic [1:0] compareOutputActionB_reg;
  logic [WIDTH-1:0] timerCount_reg;
  logic [WIDTH-1:0] timerCount_next;
  logic [WIDTH-1:0] compareValueA_reg;
  logic [WIDTH-1:0] compareValueB_reg;
  logic [WIDTH-1:0] captureValue_reg;
  logic [3:0] pinCtrl_reg;
  logic blockMatch_reg;
  logic [WIDTH-1:0] topValue;
  logic clearOnTop;
  logic pwmMode;
  logic topHit;
  logic countWrite;
  logic forceWrite;
  logic flagWrite;
  logic compareOutputStateA;
  logic compareOutputStateB;
  logic [15:0] readMux;

  assign countWrite = regWrite && (regAddr == T16OC_OFF_COUNT);
  assign flagWrite = regWrite && (regAddr == T16OC_OFF_FLAGS);
  assign forceWrite = regWrite && (regAddr == T16OC_OFF_FORCE) && !pwmMode;

  // mode decode; dual-slope pwm modes are kept single-slope here
  always_comb begin
    pwmMode = 1'b1;
    clearOnTop = 1'b0;
    topValue = T16OC_MAX;
    case (waveformModeSelect_reg)
      T16OC_MODE_NORMAL: begin
        pwmMode = 1'b0;
      end
      T16OC_MODE_CTC_CMPA: begin
        pwmMode = 1'b0;
        clearOnTop = 1'b1;
        topValue = compareValueA_reg;
      end
      T16OC_MODE_CTC_CAPT: begin
        pwmMode = 1'b0;
        clearOnTop = 1'b1;
        topValue = captureValue_reg;
      end
      T16OC_MODE_RESV: begin
        pwmMode = 1'b0;
      end
      T16OC_MODE_FAST8: begin
        clearOnTop = 1'b1;
        topValue = T16OC_TOP8;
      end
      T16OC_MODE_FAST9: begin
        clearOnTop = 1'b1;
        topValue = T16OC_TOP9;
      end
      T16OC_MODE_FAST10: begin
        clearOnTop = 1'b1;
        topValue = T16OC_TOP10;
      end
      T16OC_MODE_FAST_CAPT: begin
        clearOnTop = 1'b1;
        topValue = captureValue_reg;
      end
      T16OC_MODE_FAST_CMPA: begin
        clearOnTop = 1'b1;
        topValue = compareValueA_reg;
      end
      default: begin
        pwmMode = 1'b1;
      end
    endcase
  end

  // a blocked tick cannot see the top match, so the count runs on to max
  assign topHit = timerTick && clearOnTop && !blockMatch_reg && (timerCount_reg == topValue);

  // only the mode field steers counting, never the action fields
  always_comb begin
    timerCount_next = timerCount_reg;
    if (countWrite) begin
      timerCount_next = regWdata[WIDTH-1:0];
    end else if (topHit) begin
      timerCount_next = T16OC_BOTTOM;
    end else if (timerTick) begin
      timerCount_next = timerCount_reg + 1'b1;
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      timerCount_reg <= T16OC_RST_WORD;
    end else begin
      timerCount_reg <= timerCount_next;
    end
  end

  // block stays armed through a stopped clock until the next tick
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      blockMatch_reg <= 1'b0;
    end else if (countWrite) begin
      blockMatch_reg <= 1'b1;
    end else if (timerTick) begin
      blockMatch_reg <= 1'b0;
    end
  end

  // overflow: set wins over ack and write-one clear
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      overflowFlag <= 1'b0;
    end else if (!countWrite && (pwmMode ? topHit :
                 (timerTick && timerCount_reg == T16OC_MAX))) begin
      overflowFlag <= 1'b1;
    end else if (overflowIntAck || (flagWrite && regWdata[T16OC_FLAG_OVF_BIT])) begin
      overflowFlag <= 1'b0;
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      waveformModeSelect_reg <= T16OC_RST_MODE;
      compareOutputActionA_reg <= T16OC_RST_ACT;
      compareOutputActionB_reg <= T16OC_RST_ACT;
    end else if (regWrite && regAddr == T16OC_OFF_CTRL) begin
      waveformModeSelect_reg <= regWdata[T16OC_CTRL_MODE_LSB +: 4];
      compareOutputActionA_reg <= regWdata[T16OC_CTRL_ACTA_LSB +: 2];
      compareOutputActionB_reg <= regWdata[T16OC_CTRL_ACTB_LSB +: 2];
    end
  end

  // compare values unbuffered: pwm double buffering is outside this block
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      compareValueA_reg <= T16OC_RST_WORD;
      compareValueB_reg <= T16OC_RST_WORD;
      captureValue_reg <= T16OC_RST_WORD;
      pinCtrl_reg <= T16OC_RST_WORD[3:0];
    end else if (regWrite) begin
      if (regAddr == T16OC_OFF_CMPA) compareValueA_reg <= regWdata[WIDTH-1:0];
      if (regAddr == T16OC_OFF_CMPB) compareValueB_reg <= regWdata[WIDTH-1:0];
      if (regAddr == T16OC_OFF_CAPT) captureValue_reg <= regWdata[WIDTH-1:0];
      if (regAddr == T16OC_OFF_PIN) pinCtrl_reg <= regWdata[3:0];
    end
  end

  // channel a and b are identical and independent
  t16oc_channel #(.WIDTH(WIDTH)) chanA (
    .mclk(mclk),
    .resetn(resetn),
    .count(timerCount_reg),
    .compareValue(compareValueA_reg),
    .timerTick(timerTick),
    .blockMatch(blockMatch_reg),
    .compareOutputAction(compareOutputActionA_reg),
    .pwmMode(pwmMode),
    .topHit(topHit),
    .forceCompareStrobe(forceWrite && regWdata[T16OC_FORCE_A_BIT]),
    .flagClear(flagWrite && regWdata[T16OC_FLAG_MA_BIT]),
    .compareMatchFlag(compareMatchFlagA),
    .compareOutputState(compareOutputStateA)
  );

  t16oc_channel #(.WIDTH(WIDTH)) chanB (
    .mclk(mclk),
    .resetn(resetn),
    .count(timerCount_reg),
    .compareValue(compareValueB_reg),
    .timerTick(timerTick),
    .blockMatch(blockMatch_reg),
    .compareOutputAction(compareOutputActionB_reg),
    .pwmMode(pwmMode),
    .topHit(topHit),
    .forceCompareStrobe(forceWrite && regWdata[T16OC_FORCE_B_BIT]),
    .flagClear(flagWrite && regWdata[T16OC_FLAG_MB_BIT]),
    .compareMatchFlag(compareMatchFlagB),
    .compareOutputState(compareOutputStateB)
  );

  // pin mux registered; direction alone gates the driver
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      pinOutA <= 1'b0;
      pinOutB <= 1'b0;
      pinOeNA <= 1'b1;
      pinOeNB <= 1'b1;
    end else begin
      pinOutA <= (compareOutputActionA_reg != T16OC_ACT_NONE) ?
                 compareOutputStateA : pinCtrl_reg[T16OC_PIN_PORTA_BIT];
      pinOutB <= (compareOutputActionB_reg != T16OC_ACT_NONE) ?
                 compareOutputStateB : pinCtrl_reg[T16OC_PIN_PORTB_BIT];
      pinOeNA <= !pinCtrl_reg[T16OC_PIN_DIRA_BIT];
      pinOeNB <= !pinCtrl_reg[T16OC_PIN_DIRB_BIT];
    end
  end

  // force register always reads zero: strobes hold no state
  always_comb begin
    readMux = 16'h0000;
    case (regAddr)
      T16OC_OFF_CTRL: begin
        readMux[T16OC_CTRL_MODE_LSB +: 4] = waveformModeSelect_reg;
        readMux[T16OC_CTRL_ACTA_LSB +: 2] = compareOutputActionA_reg;
        readMux[T16OC_CTRL_ACTB_LSB +: 2] = compareOutputActionB_reg;
      end
      T16OC_OFF_COUNT: readMux[WIDTH-1:0] = timerCount_reg;
      T16OC_OFF_CMPA: readMux[WIDTH-1:0] = compareValueA_reg;
      T16OC_OFF_CMPB: readMux[WIDTH-1:0] = compareValueB_reg;
      T16OC_OFF_CAPT: readMux[WIDTH-1:0] = captureValue_reg;
      T16OC_OFF_FLAGS: begin
        readMux[T16OC_FLAG_OVF_BIT] = overflowFlag;
        readMux[T16OC_FLAG_MA_BIT] = compareMatchFlagA;
        readMux[T16OC_FLAG_MB_BIT] = compareMatchFlagB;
      end
      T16OC_OFF_PIN: readMux[3:0] = pinCtrl_reg;
      default: readMux = 16'h0000;
    endcase
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      regRdata <= 16'h0000;
    end else begin
      regRdata <= regRead ? readMux : 16'h0000;
    end
  end

  a_force_no_flag: assert property (
    @(posedge mclk) disable iff (!resetn)
    (forceWrite && !timerTick && !compareMatchFlagA) |=> !compareMatchFlagA
  ) else $error("forced compare set the match flag");

  a_force_keeps_count: assert property (
    @(posedge mclk) disable iff (!resetn)
    (forceWrite && !timerTick) |=> (timerCount_reg == $past(timerCount_reg))
  ) else $error("forced compare changed the counter");

  a_block_after_write: assert property (
    @(posedge mclk) disable iff (!resetn)
    (blockMatch_reg && timerTick && !compareMatchFlagA) |=> !compareMatchFlagA
  ) else $error("match not blocked after counter write");

  a_top_lost_write: assert property (
    @(posedge mclk) disable iff (!resetn)
    (pwmMode && clearOnTop && blockMatch_reg && timerTick && !countWrite &&
     timerCount_reg == topValue && timerCount_reg != T16OC_MAX)
      |=> (timerCount_reg == $past(timerCount_reg) + 16'h0001)
  ) else $error("blocked top match still cleared the counter");

  a_normal_wrap: assert property (
    @(posedge mclk) disable iff (!resetn)
    (waveformModeSelect_reg == T16OC_MODE_NORMAL && timerTick && !countWrite &&
     timerCount_reg == T16OC_MAX) |=> (timerCount_reg == T16OC_BOTTOM) && overflowFlag
  ) else $error("normal mode wrap did not reach zero with overflow");

  a_match_sets_flag: assert property (
    @(posedge mclk) disable iff (!resetn)
    (timerTick && !blockMatch_reg && timerCount_reg == compareValueB_reg)
      |=> compareMatchFlagB
  ) else $error("match flag b not set on equality");

  a_overflow_sticky: assert property (
    @(posedge mclk) disable iff (!resetn)
    (overflowFlag && !overflowIntAck && !flagWrite) |=> overflowFlag
  ) else $error("overflow flag cleared without a clear request");

  a_pin_override: assert property (
    @(posedge mclk) disable iff (!resetn)
    (compareOutputActionA_reg != T16OC_ACT_NONE) |=> (pinOutA == $past(compareOutputStateA))
  ) else $error("pin a not driven from output state");

  a_pin_direction: assert property (
    @(posedge mclk) disable iff (!resetn)
    $rose(pinCtrl_reg[T16OC_PIN_DIRB_BIT]) |=> !pinOeNB
  ) else $error("pin b enable did not follow direction bit");

  a_read_count: assert property (
    @(posedge mclk) disable iff (!resetn)
    (regRead && regAddr == T16OC_OFF_COUNT) |=> (regRdata == $past(timerCount_reg))
  ) else $error("counter read returned wrong value");

  // without a tick nothing but a force may move the state, and pwm drops forces
  a_pwm_force_hold: assert property (
    @(posedge mclk) disable iff (!resetn)
    (pwmMode && regWrite && regAddr == T16OC_OFF_FORCE && !timerTick)
      |=> $stable(compareOutputStateA)
  ) else $error("forced compare acted in a pwm mode");

  a_normal_count: assert property (
    @(posedge mclk) disable iff (!resetn)
    (waveformModeSelect_reg == T16OC_MODE_NORMAL && timerTick && !countWrite &&
     timerCount_reg != T16OC_MAX) |=> (timerCount_reg == $past(timerCount_reg) + 16'h0001)
  ) else $error("normal mode did not increment");

  a_block_release: assert property (
    @(posedge mclk) disable iff (!resetn)
    (blockMatch_reg && timerTick && !countWrite) |=> !blockMatch_reg
  ) else $error("match block outlived one timer tick");
endmodule

/* File: verification/t16oc_pin_model.sv */
// pad model for one compare output pin, as seen from the board
`timescale 1ns/100ps
module t16oc_pin_model (
  input wire logic mclk, // system clock
  input wire logic pinOut, // level offered by the timer
  input wire logic pinOeN, // low while the timer drives
  output logic pinLevel // level on the pad
);
  logic lastLevel_reg = 1'b0;

  always_ff @(posedge mclk) begin
    if (!pinOeN) begin
      lastLevel_reg <= pinOut;
    end
  end

  // a released pad has no keeper: show the inverse so a stale level never passes
  assign pinLevel = pinOeN ? ~lastLevel_reg : pinOut;
endmodule

/* File: verification/timer16_output_compare_normal_tb.sv */
// self-checking bench for the 16-bit timer compare block
`timescale 1ns/100ps
module timer16_output_compare_normal_tb
  import t16oc_pkg::*;
;
  logic mclk = 1'b0;
  logic resetn = 1'b0;
  logic timerTick = 1'b0;
  logic overflowIntAck = 1'b0;
  logic [3:0] regAddr = 4'h0;
  logic [15:0] regWdata = 16'h0000;
  logic regWrite = 1'b0;
  logic regRead = 1'b0;
  logic [15:0] regRdata;
  logic pinOutA, pinOeNA, pinOutB, pinOeNB;
  logic overflowFlag, compareMatchFlagA, compareMatchFlagB;
  logic lvlA, lvlB;
  int badCount = 0;
  int checks = 0;
  logic [1:0] acts [3] = '{T16OC_ACT_CLEAR, T16OC_ACT_SET, T16OC_ACT_TOGGLE};
  logic exps [3] = '{1'b0, 1'b1, 1'b0};

  always #20 mclk = ~mclk;

  t16oc_timer dut (
    .mclk(mclk), .resetn(resetn), .timerTick(timerTick), .overflowIntAck(overflowIntAck),
    .regAddr(regAddr), .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead),
    .regRdata(regRdata), .pinOutA(pinOutA), .pinOeNA(pinOeNA), .pinOutB(pinOutB),
    .pinOeNB(pinOeNB), .overflowFlag(overflowFlag), .compareMatchFlagA(compareMatchFlagA),
    .compareMatchFlagB(compareMatchFlagB)
  );
  t16oc_pin_model padA (.mclk(mclk), .pinOut(pinOutA), .pinOeN(pinOeNA), .pinLevel(lvlA));
  t16oc_pin_model padB (.mclk(mclk), .pinOut(pinOutB), .pinOeN(pinOeNB), .pinLevel(lvlB));

  function automatic logic [15:0] cv(input logic [3:0] m, input logic [1:0] a, input logic [1:0] b);
    cv = {8'h00, b, a, m};
  endfunction

  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    checks++;
    if (g !== e) begin
      badCount++;
      $display("CHECK FAILED at %0t got %h exp %h", $time, g, e);
    end
  endtask

  task automatic chkb(input logic g, input logic e);
    chk({15'h0000, g}, {15'h0000, e});
  endtask

  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge mclk);
    regAddr <= a;
    regWdata <= d;
    regWrite <= 1'b1;
    @(posedge mclk);
    regWrite <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, input logic [15:0] e);
    @(posedge mclk);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge mclk);
    regRead <= 1'b0;
    #1;
    chk(regRdata, e);
  endtask

  task automatic tk(input int n);
    repeat (n) begin
      @(posedge mclk);
      timerTick <= 1'b1;
      @(posedge mclk);
      timerTick <= 1'b0;
    end
  endtask

  // state and pins are registered twice after the causing edge
  task automatic w3();
    repeat (3) @(posedge mclk);
    #1;
  endtask

  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", checks, badCount);
    if (badCount == 0 && checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge mclk);
    badCount++;
    wrap_up();
  end

  initial begin
    repeat (5) @(posedge mclk);
    resetn <= 1'b1;
    #1;
    chkb(pinOeNA, 1'b1);
    chkb(overflowFlag, 1'b0);
    rd(T16OC_OFF_COUNT, 16'h0000);
    // port value shows while the action field is zero
    wr(T16OC_OFF_PIN, 16'h000C);
    w3();
    chkb(lvlB, 1'b1);
    chkb(pinOeNB, 1'b0);
    wr(T16OC_OFF_CTRL, cv(T16OC_MODE_NORMAL, T16OC_ACT_TOGGLE, T16OC_ACT_SET));
    w3();
    chkb(lvlB, 1'b0);
    // preset channel a by force before enabling its driver
    wr(T16OC_OFF_FORCE, 16'h0001);
    wr(T16OC_OFF_PIN, 16'h000E);
    w3();
    chkb(lvlA, 1'b1);
    chkb(compareMatchFlagA, 1'b0);
    rd(T16OC_OFF_COUNT, 16'h0000);
    for (int i = 0; i < 3; i++) begin
      wr(T16OC_OFF_CTRL, cv(T16OC_MODE_NORMAL, acts[i], T16OC_ACT_SET));
      wr(T16OC_OFF_FORCE, 16'h0001);
      w3();
      chkb(lvlA, exps[i]);
    end
    wr(T16OC_OFF_CTRL, cv(T16OC_MODE_NORMAL, T16OC_ACT_NONE, T16OC_ACT_SET));
    wr(T16OC_OFF_FORCE, 16'h0001);
    wr(T16OC_OFF_CTRL, cv(T16OC_MODE_NORMAL, T16OC_ACT_TOGGLE, T16OC_ACT_SET));
    w3();
    chkb(lvlA, 1'b0);
    // force is ignored in a pwm mode and states survive the mode change
    wr(T16OC_OFF_CTRL, cv(T16OC_MODE_FAST8, T16OC_ACT_SET, T16OC_ACT_SET));
    wr(T16OC_OFF_FORCE, 16'h0003);
    w3();
    chkb(lvlA, 1'b0);
    chkb(lvlB, 1'b0);
    wr(T16OC_OFF_CTRL, cv(T16OC_MODE_NORMAL, T16OC_ACT_TOGGLE, T16OC_ACT_SET));
    w3();
    chkb(lvlA, 1'b0);
    // a counter write hides the match on the next tick, even after a long stop
    wr(T16OC_OFF_CMPA, 16'h0005);
    wr(T16OC_OFF_CMPB, 16'h0007);
    wr(T16OC_OFF_COUNT, 16'h0005);
    repeat (20) @(posedge mclk);
    tk(1);
    w3();
    chkb(compareMatchFlagA, 1'b0);
    rd(T16OC_OFF_COUNT, 16'h0006);
    wr(T16OC_OFF_COUNT, 16'h0004);
    tk(2);
    w3();
    chkb(compareMatchFlagA, 1'b1);
    chkb(lvlA, 1'b1);
    chkb(compareMatchFlagB, 1'b0);
    tk(2);
    w3();
    chkb(lvlB, 1'b1);
    rd(T16OC_OFF_FLAGS, 16'h0006);
    wr(T16OC_OFF_FLAGS, 16'h0006);
    rd(T16OC_OFF_FLAGS, 16'h0000);
    // wrap from the top of the count range
    wr(T16OC_OFF_COUNT, 16'hFFFF);
    tk(1);
    w3();
    chkb(overflowFlag, 1'b1);
    rd(T16OC_OFF_COUNT, 16'h0000);
    @(posedge mclk);
    overflowIntAck <= 1'b1;
    @(posedge mclk);
    overflowIntAck <= 1'b0;
    w3();
    chkb(overflowFlag, 1'b0);
    // writing the variable top loses that top
    wr(T16OC_OFF_CAPT, 16'h0008);
    wr(T16OC_OFF_CTRL, cv(T16OC_MODE_FAST_CAPT, T16OC_ACT_NONE, T16OC_ACT_NONE));
    wr(T16OC_OFF_COUNT, 16'h0008);
    tk(2);
    rd(T16OC_OFF_COUNT, 16'h000A);
    // non-inverted then inverted polarity on an 8-bit single-slope count
    wr(T16OC_OFF_CTRL, cv(T16OC_MODE_FAST8, T16OC_ACT_CLEAR, T16OC_ACT_NONE));
    wr(T16OC_OFF_CMPA, 16'h0002);
    wr(T16OC_OFF_COUNT, 16'h0001);
    tk(2);
    w3();
    chkb(lvlA, 1'b0);
    wr(T16OC_OFF_COUNT, 16'h00FE);
    tk(2);
    w3();
    chkb(lvlA, 1'b1);
    wr(T16OC_OFF_CTRL, cv(T16OC_MODE_FAST8, T16OC_ACT_SET, T16OC_ACT_NONE));
    w3();
    chkb(lvlA, 1'b1);
    wr(T16OC_OFF_COUNT, 16'h00FE);
    tk(2);
    w3();
    chkb(lvlA, 1'b0);
    // compare a as top in ctc: force still works, the top match clears the count
    wr(T16OC_OFF_CTRL, cv(T16OC_MODE_CTC_CMPA, T16OC_ACT_TOGGLE, T16OC_ACT_NONE));
    wr(T16OC_OFF_FORCE, 16'h0001);
    w3();
    chkb(lvlA, 1'b1);
    wr(T16OC_OFF_COUNT, 16'h0001);
    tk(3);
    rd(T16OC_OFF_COUNT, 16'h0001);
    chkb(lvlA, 1'b0);
    rd(T16OC_OFF_CAPT, 16'h0008);
    // unmapped place reads zero and swallows writes
    wr(4'h9, 16'hFFFF);
    rd(4'h9, 16'h0000);
    rd(T16OC_OFF_CTRL, cv(T16OC_MODE_CTC_CMPA, T16OC_ACT_TOGGLE, T16OC_ACT_NONE));
    wrap_up();
  end
endmodule
